// file: include/fxc_pkg.sv
// Constants, modes and state types shared by the expandable FIFO block
package fxc_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int AW     = 8;
  localparam int CNT_W  = 9;
  localparam logic [CNT_W-1:0] DEPTH     = 9'h100;  // Physical words in the array
  localparam logic [CNT_W-1:0] CAP_STD   = 9'h100;  // Capacity in standard timing
  localparam logic [CNT_W-1:0] CAP_FALL  = 9'h101;  // Output register adds one word
  localparam logic [AW-1:0]    LAST_LOC  = 8'hff;   // Last physical location
  localparam logic [CNT_W-1:0] AE_OFFSET = 9'h007;  // Default almost-empty distance
  localparam logic [CNT_W-1:0] AF_OFFSET = 9'h007;  // Default almost-full distance
  localparam logic [CNT_W-1:0] HF_LEVEL  = 9'h081;  // More than half of the array
  localparam logic [1:0]       INIT_LATCH = 2'h2;   // Strap sample cycle after release
  localparam logic [1:0]       INIT_DONE  = 2'h3;

  // ---------------------------------------------------------------
  // Strap patterns, order {first_load, read_exp_in, write_exp_in}
  // ---------------------------------------------------------------
  localparam logic [2:0] STRAP_STD2_A  = 3'h2;
  localparam logic [2:0] STRAP_STD2_B  = 3'h6;
  localparam logic [2:0] STRAP_FALL_A  = 3'h1;
  localparam logic [2:0] STRAP_FALL_B  = 3'h5;
  localparam logic [2:0] STRAP_DAISY_A = 3'h3;
  localparam logic [2:0] STRAP_DAISY_B = 3'h7;

  typedef enum logic [1:0] {
    MODE_STD1  = 2'b00,  // Standard, single-buffered flags
    MODE_STD2  = 2'b01,  // Standard, double-buffered flags
    MODE_FALL  = 2'b10,  // First word falls through
    MODE_DAISY = 2'b11   // Daisy-chain depth expansion
  } fxc_mode_type;

  typedef struct packed {
    logic [2:0]        strap_s1;
    logic [2:0]        strap_s2;
    logic [1:0]        init;
    fxc_mode_type      mode;
    logic              wtok;
    logic              rtok;
    logic [AW-1:0]     wptr;
    logic [AW-1:0]     rptr;
    logic [AW-1:0]     wacc;
    logic [CNT_W-1:0]  mem_cnt;
    logic [CNT_W-1:0]  total;
    logic              emp_s1;
    logic              emp_s2;
    logic              full_s1;
    logic              full_s2;
    logic              ae;
    logic              af;
    logic              half;
    logic              out_v;
    logic [DATA_W-1:0] dout;
    logic              wr_pass;
    logic              rd_pass;
  } fxc_core_type;

  // Empty and almost-empty start asserted, everything else clear
  localparam fxc_core_type CORE_RST = '{mode: MODE_STD1, emp_s1: 1'b1, emp_s2: 1'b1,
                                        ae: 1'b1, default: '0};

endpackage

// file: include/fxc_stream_if.sv
// Valid/ready word carrier between the core and its two-entry buffer
`timescale 1ns/10ps
`default_nettype none
interface fxc_stream_if;
  import fxc_pkg::*;
  logic              valid;
  logic              ready;
  logic [DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: rtl/fxc_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module fxc_skid
  import fxc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  fxc_stream_if.snk in_s,
  fxc_stream_if.src out_s
);

  typedef struct packed {
    logic [DATA_W-1:0] e0;
    logic [DATA_W-1:0] e1;
    logic [1:0]        cnt;
  } fxc_skid_type;

  fxc_skid_type s_r;
  fxc_skid_type s_nxt;
  logic         push;
  logic         pop;

  // ---------------------------------------------------------------
  // Handshakes
  // ---------------------------------------------------------------
  // Ready depends only on occupancy, so no loop through the source
  assign in_s.ready  = (s_r.cnt != 2'h2);
  assign out_s.valid = (s_r.cnt != 2'h0);
  assign out_s.data  = s_r.e0;
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // Entry zero is always the head
  always_comb begin
    s_nxt = s_r;
    if (push && pop) begin
      if (s_r.cnt == 2'h1) begin
        s_nxt.e0 = in_s.data;
      end else begin
        s_nxt.e0 = s_r.e1;
        s_nxt.e1 = in_s.data;
      end
    end else if (push) begin
      if (s_r.cnt == 2'h0) begin
        s_nxt.e0 = in_s.data;
      end else begin
        s_nxt.e1 = in_s.data;
      end
      s_nxt.cnt = s_r.cnt + 2'h1;
    end else if (pop) begin
      s_nxt.e0  = s_r.e1;
      s_nxt.cnt = s_r.cnt - 2'h1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  a_skid_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    s_r.cnt <= 2'h2) else $error("buffer occupancy above two");
  a_skid_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (out_s.valid && !out_s.ready) |=> (out_s.valid && $stable(out_s.data)))
    else $error("buffer head changed while stalled");

endmodule // fxc_skid
`default_nettype wire

// file: rtl/fxc_fifo_core.sv
// Expandable synchronous FIFO: strap modes, flag timing and chain expansion
//
// Contract
// R01 - Double-buffered empty flag clears one cycle after the single-buffered one.
// R02 - Straps 010 or 110 select standard mode with double-buffered flags.
// R03 - Straps 001 or 101 select fall-through mode with output-ready.
// R04 - Output-ready follows the output register directly, no extra flag stage.
// R05 - Six strap patterns give a standalone device; 011 and 111 do not.
// R06 - Width expansion: outside logic merges empty/ready and full/ready separately.
// R07 - Width expansion: share input controls, never tie outputs together.
// R08 - Daisy chain: first device first-load low, all others high.
// R09 - Daisy chain: write-expansion out feeds next device's input, in a ring.
// R10 - Daisy chain: read-expansion out feeds next device's input, in a ring.
// R11 - Daisy chain: all offset-load inputs driven from one signal.
// R12 - Half-full output is held inactive in daisy-chain mode.
// R13 - Daisy chain: composite flags are ORed outside; almost flags are approximate.
// R14 - Daisy chain: single-buffered full/empty, unregistered almost flags.
// R15 - Fall-through chain: data wired straight through, all devices in that mode.
// R16 - Fall-through: a word reaches the outputs unread and output-ready goes low.
// R17 - Fall-through chain: every read clock runs freely.
// R18 - Fall-through: a freed slot drives input-ready low next cycle.
// R19 - Fall-through chain: transfer clock is the faster of the two clocks.
// R20 - Chain capacity is the sum of each device's capacity.
// R21 - Only the first word into an empty chain sees the ripple delay.
// R22 - Fall-through capacity is one word above the array depth.
// R23 - Daisy chain: pulse expansion outputs on last-location write and read.
`timescale 1ns/10ps
`default_nettype none
module fxc_fifo_core
  import fxc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              wen_n,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              ren_n,
  output logic      [DATA_W-1:0] dout,
  input  wire logic              first_load_strap_n,
  input  wire logic              read_expansion_in_n,
  input  wire logic              write_expansion_in_n,
  output logic                   empty_indicator,
  output logic                   full_indicator,
  output logic                   almost_empty_indicator_n,
  output logic                   almost_full_indicator_n,
  output logic                   half_full_indicator_n,
  output logic                   write_expansion_out_n,
  output logic                   read_expansion_out_n
);

  fxc_core_type      s_r;
  fxc_core_type      s_nxt;
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  fxc_stream_if      wr_s ();
  fxc_stream_if      mem_s ();
  fxc_mode_type      strap_mode;
  logic              done;
  logic              fall_through_mode;
  logic              daisy;
  logic [CNT_W-1:0]  cap;
  logic              emp_shown;
  logic              full_shown;
  logic              wr_acc;
  logic              mem_we;
  logic              rd_acc;
  logic              pop;
  logic              load;
  logic              mem_rd;
  logic              leave;

  // ---------------------------------------------------------------
  // Input buffer
  // ---------------------------------------------------------------
  // Pins land in the buffer; it drains into the array when room exists
  fxc_skid fxc_skid_inst (
    .mclk  (mclk),
    .rst_n (rst_n),
    .in_s  (wr_s),
    .out_s (mem_s)
  );

  // ---------------------------------------------------------------
  // Mode decode and handshakes
  // ---------------------------------------------------------------
  // Strap decode of the synchronised pins
  always_comb begin
    case (s_r.strap_s2)
      STRAP_STD2_A, STRAP_STD2_B:   strap_mode = MODE_STD2;   // R02
      STRAP_FALL_A, STRAP_FALL_B:   strap_mode = MODE_FALL;   // R03
      STRAP_DAISY_A, STRAP_DAISY_B: strap_mode = MODE_DAISY;  // R05
      default:                      strap_mode = MODE_STD1;   // R05
    endcase
  end

  assign done  = (s_r.init == INIT_DONE);
  assign fall_through_mode = (s_r.mode == MODE_FALL);
  assign daisy = (s_r.mode == MODE_DAISY);
  assign cap   = fall_through_mode ? CAP_FALL : CAP_STD;  // R22
  // Only standard-double adds a second flag stage; daisy keeps one
  assign emp_shown  = (s_r.mode == MODE_STD2) ? s_r.emp_s2 : s_r.emp_s1;    // R01 R14
  assign full_shown = (s_r.mode == MODE_STD2) ? s_r.full_s2 : s_r.full_s1;  // R14

  // A write is refused while full, before init, or without the token
  assign wr_s.valid  = done && !wen_n && s_r.wtok && (s_r.total < cap);
  assign wr_s.data   = din;
  assign wr_acc      = wr_s.valid && wr_s.ready;
  assign mem_s.ready = (s_r.mem_cnt != DEPTH);
  assign mem_we      = mem_s.valid && mem_s.ready;

  // Standard reads obey the shown flag; fall-through prefetches freely
  assign rd_acc = done && !fall_through_mode && !ren_n && s_r.rtok && !emp_shown &&
                  (s_r.mem_cnt != '0);
  assign pop    = fall_through_mode && !ren_n && s_r.out_v;
  assign load   = fall_through_mode && (s_r.mem_cnt != '0) && (!s_r.out_v || pop);  // R16 R21
  assign mem_rd = rd_acc || load;
  assign leave  = rd_acc || pop;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.strap_s1 = {first_load_strap_n, read_expansion_in_n, write_expansion_in_n};
    s_nxt.strap_s2 = s_r.strap_s1;
    s_nxt.wr_pass  = 1'b0;
    s_nxt.rd_pass  = 1'b0;
    if (s_r.init != INIT_DONE) begin
      s_nxt.init = s_r.init + 2'h1;
    end
    // Mode is fixed once and the tokens loaded, when the straps have settled
    if (s_r.init == INIT_LATCH) begin
      s_nxt.mode = strap_mode;
      s_nxt.wtok = (strap_mode != MODE_DAISY) || !s_r.strap_s2[2];
      s_nxt.rtok = (strap_mode != MODE_DAISY) || !s_r.strap_s2[2];
    end
    if (wr_acc) begin
      s_nxt.wacc = s_r.wacc + 8'h01;
      if (daisy && (s_r.wacc == LAST_LOC)) begin
        s_nxt.wr_pass = 1'b1;  // R23
        s_nxt.wtok = 1'b0;  // R23
      end
    end
    if (mem_we) begin
      s_nxt.wptr = s_r.wptr + 8'h01;
    end
    if (mem_rd) begin
      s_nxt.rptr = s_r.rptr + 8'h01;
      s_nxt.dout = mem[s_r.rptr];
      if (daisy && (s_r.rptr == LAST_LOC)) begin
        s_nxt.rd_pass = 1'b1;  // R23
        s_nxt.rtok = 1'b0;  // R23
      end
    end
    // Token arrival wins over a hand-off in the same cycle
    if (daisy && !write_expansion_in_n) begin
      s_nxt.wtok = 1'b1;
    end
    if (daisy && !read_expansion_in_n) begin
      s_nxt.rtok = 1'b1;
    end
    if (load) begin
      s_nxt.out_v = 1'b1;  // R16
    end else if (pop) begin
      s_nxt.out_v = 1'b0;
    end
    s_nxt.mem_cnt = s_r.mem_cnt + CNT_W'(mem_we) - CNT_W'(mem_rd);
    s_nxt.total   = s_r.total + CNT_W'(wr_acc) - CNT_W'(leave);  // R20 R22
    // Flags take one stage from the next counts, the double path one more
    s_nxt.emp_s1  = (s_nxt.mem_cnt == '0);
    s_nxt.emp_s2  = s_r.emp_s1;  // R01
    s_nxt.full_s1 = (s_nxt.total >= cap);  // R18
    s_nxt.full_s2 = s_r.full_s1;
    s_nxt.ae      = (s_nxt.mem_cnt <= AE_OFFSET);
    s_nxt.af      = (s_nxt.total >= (cap - AF_OFFSET));
    s_nxt.half    = (s_nxt.total >= HF_LEVEL);
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array write port; kept out of the state record because of its size
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[s_r.wptr] <= mem_s.data;
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  // Fall-through shows output-ready and input-ready, both active low
  assign dout                     = s_r.dout;
  assign empty_indicator          = fall_through_mode ? !s_r.out_v : !emp_shown;   // R04 R16
  assign full_indicator           = fall_through_mode ? full_shown : !full_shown;  // R18
  // Daisy almost flags decode the live count, so they can glitch
  assign almost_empty_indicator_n = daisy ? !(s_r.mem_cnt <= AE_OFFSET) : !s_r.ae;  // R14
  assign almost_full_indicator_n  = daisy ? !(s_r.total >= (cap - AF_OFFSET)) : !s_r.af;  // R14
  assign half_full_indicator_n    = daisy ? 1'b1 : !s_r.half;  // R12
  assign write_expansion_out_n    = !s_r.wr_pass;
  assign read_expansion_out_n     = !s_r.rd_pass;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_latch_fall;
    (s_r.init == INIT_LATCH) && (strap_mode == MODE_FALL);
  endsequence
  sequence s_fill;
    fall_through_mode && (s_r.mem_cnt != '0) && !s_r.out_v;
  endsequence
  sequence s_last_write;
    daisy && wr_acc && (s_r.wacc == LAST_LOC);
  endsequence

  a_mode_fall: assert property (@(posedge mclk) disable iff (!rst_n) // R03
    s_latch_fall |=> (fall_through_mode && done)) else $error("fall-through strap not taken");
  a_mode_std2: assert property (@(posedge mclk) disable iff (!rst_n) // R02
    ((s_r.init == INIT_LATCH) && ((s_r.strap_s2 == STRAP_STD2_A) ||
     (s_r.strap_s2 == STRAP_STD2_B))) |=> (s_r.mode == MODE_STD2))
    else $error("double-buffered strap not taken");
  a_mode_single: assert property (@(posedge mclk) disable iff (!rst_n) // R05
    ((s_r.init == INIT_LATCH) && (s_r.strap_s2 != STRAP_DAISY_A) &&
     (s_r.strap_s2 != STRAP_DAISY_B)) |=> !daisy) else $error("standalone strap gave chain mode");
  a_emp_double_lag: assert property (@(posedge mclk) disable iff (!rst_n) // R01
    ((s_r.mode == MODE_STD2) && $fell(s_r.emp_s1)) |-> (!empty_indicator ##1 empty_indicator))
    else $error("double-buffered empty flag timing wrong");
  a_or_fall_through: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    s_fill |=> (s_r.out_v && !empty_indicator)) else $error("word did not fall through");
  a_stream_no_gap: assert property (@(posedge mclk) disable iff (!rst_n) // R21
    (pop && (s_r.mem_cnt != '0)) |=> !empty_indicator) else $error("gap behind first word");
  a_bubble_up: assert property (@(posedge mclk) disable iff (!rst_n) // R18
    (fall_through_mode && full_indicator && pop) |=> !full_indicator)
    else $error("freed slot not shown");
  a_fall_capacity: assert property (@(posedge mclk) disable iff (!rst_n) // R22
    (fall_through_mode && (s_r.total == CAP_FALL)) |-> (full_indicator && !wr_acc))
    else $error("fall-through capacity wrong");
  a_half_daisy: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    daisy |-> half_full_indicator_n) else $error("half-full active in chain mode");
  a_ae_async: assert property (@(posedge mclk) disable iff (!rst_n) // R14
    (daisy && (s_r.mem_cnt == '0)) |-> (!almost_empty_indicator_n && !empty_indicator))
    else $error("chain flags not live");
  a_wr_pass_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // R23
    s_last_write |=> (!write_expansion_out_n ##1 write_expansion_out_n))
    else $error("write hand-off pulse wrong");
  a_rd_pass_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // R23
    (daisy && rd_acc && (s_r.rptr == LAST_LOC)) |=> (!read_expansion_out_n ##1 read_expansion_out_n))
    else $error("read hand-off pulse wrong");

endmodule // fxc_fifo_core
`default_nettype wire

// file: sim/fxc_reader_model.sv
// Downstream reader model that pops a fall-through FIFO while output-ready shows a word
`timescale 1ns/10ps
`default_nettype none
module fxc_reader_model
  import fxc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              en,
  input  wire logic              stall,
  input  wire logic [DATA_W-1:0] dout,
  input  wire logic              empty_indicator,
  output logic                   ren_n,
  output logic                   got,
  output logic      [DATA_W-1:0] word
);
  logic ph_r;

  initial begin
    ren_n = 1'b1;
    ph_r  = 1'b0;
    got   = 1'b0;
    word  = '0;
  end

  // ----------------------------------------------------------------
  // Request side
  // ----------------------------------------------------------------
  // Falling-edge updates keep the request steady around the sampling edge;
  // a stalled reader only asks every other cycle, a prompt one always
  always @(negedge mclk) begin
    ph_r  <= ~ph_r;
    ren_n <= ~(en & ~(stall & ph_r));
  end

  // ----------------------------------------------------------------
  // Capture side
  // ----------------------------------------------------------------
  // A word is taken at the edge where the request meets output-ready low
  always @(posedge mclk) begin
    got  <= rst_n & ~ren_n & ~empty_indicator;
    word <= dout;
  end
endmodule  // fxc_reader_model
`default_nettype wire

// file: sim/fxc_fifo_core_tb_top.sv
// Self-checking bench for the expandable FIFO core
`timescale 1ns/10ps
`default_nettype none
module fxc_fifo_core_tb_top;
  import fxc_pkg::*;
  typedef struct {
    logic [2:0] s;
    logic       emp0;
    logic       ful0;
    int         lat;
  } fxc_row_type;

  logic              mclk, rst_n, wen_n, ren_tb_n, ren_n, ren_m_n, rd_en, rd_stall, got;
  logic              load_n, rin_n, win_n, emp, ful, ae_n, af_n, half_n, wout_n, rout_n;
  logic [DATA_W-1:0] din, dout, word;
  int                fail_count, total_checks, n, k, first, bad;
  fxc_row_type       rows[8];

  // One source at a time owns the read request; two drivers are never tied together
  assign ren_n = rd_en ? ren_m_n : ren_tb_n;

  // Offsets are fixed inside the core, so no offset-load line needs sharing
  fxc_fifo_core fxc_fifo_core_inst (
    .mclk                     (mclk),
    .rst_n                    (rst_n),
    .wen_n                    (wen_n),
    .din                      (din),
    .ren_n                    (ren_n),
    .dout                     (dout),
    .first_load_strap_n       (load_n),
    .read_expansion_in_n      (rin_n),
    .write_expansion_in_n     (win_n),
    .empty_indicator          (emp),
    .full_indicator           (ful),
    .almost_empty_indicator_n (ae_n),
    .almost_full_indicator_n  (af_n),
    .half_full_indicator_n    (half_n),
    .write_expansion_out_n    (wout_n),
    .read_expansion_out_n     (rout_n)
  );

  fxc_reader_model fxc_reader_model_inst (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .en              (rd_en),
    .stall           (rd_stall),
    .dout            (dout),
    .empty_indicator (emp),
    .ren_n           (ren_m_n),
    .got             (got),
    .word            (word)
  );

  // ----------------------------------------------------------------
  // Clock, shared tasks and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Straps stay put from reset until the mode is latched three edges later
  task automatic reset_dut(input logic [2:0] s);
    rst_n = 1'b0;
    wen_n = 1'b1;
    ren_tb_n = 1'b1;
    rd_en = 1'b0;
    {load_n, rin_n, win_n} = s;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask

  task automatic end_sim;
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Whole run is about 1,300 cycles; a hang is cut off well beyond that
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, wen_n, ren_tb_n, rd_en, rd_stall, load_n, rin_n, win_n} = 8'h06;
    din = '0;
    fail_count = 0;
    total_checks = 0;
    rows[0] = '{3'h0, 1'b0, 1'b1, 1};
    rows[1] = '{3'h1, 1'b1, 1'b0, 2};
    rows[2] = '{3'h2, 1'b0, 1'b1, 2};
    rows[3] = '{3'h3, 1'b0, 1'b1, 1};
    rows[4] = '{3'h4, 1'b0, 1'b1, 1};
    rows[5] = '{3'h5, 1'b1, 1'b0, 2};
    rows[6] = '{3'h6, 1'b0, 1'b1, 2};
    rows[7] = '{3'h7, 1'b0, 1'b1, 6};
    repeat (6) @(negedge mclk);
    chk("reset flags", 18'({emp, ful, ae_n, af_n, half_n, wout_n, rout_n}), 18'h0002f);
    chk("reset data", dout, 18'h0);
    // One word per strap pattern: flag latency and polarity tell the modes apart, save single-buffered from a daisy first device
    foreach (rows[i]) begin
      reset_dut(rows[i].s);
      din = 18'h2a5a0 + 18'(i);
      wen_n = 1'b0;
      @(negedge mclk);
      wen_n = 1'b1;
      chk("idle empty", emp, rows[i].emp0);
      chk("idle full", ful, rows[i].ful0);
      n = 0;
      while (emp === rows[i].emp0 && n < 6) begin
        @(negedge mclk);
        n++;
      end
      chk("flag latency", 18'(n), 18'(rows[i].lat));
      if (rows[i].lat < 6) begin
        if (rows[i].emp0) chk("fall through data", dout, din);
        ren_tb_n = 1'b0;
        @(negedge mclk);
        ren_tb_n = 1'b1;
        if (!rows[i].emp0) chk("read data", dout, din);
        repeat (3) @(negedge mclk);
        chk("empty again", emp, rows[i].emp0);
      end
    end

    // Fall-through: fill past capacity, pop once, then drain with a reader that stalls for 60 words, then streams
    reset_dut(3'h5);
    for (k = 0; k < 262; k++) begin
      din = 18'(k);
      wen_n = 1'b0;
      @(negedge mclk);
    end
    wen_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("no room", ful, 1'b1);
    chk("almost full", af_n, 1'b0);
    chk("half full", half_n, 1'b0);
    chk("head word", dout, 18'h0);
    ren_tb_n = 1'b0;
    @(negedge mclk);
    ren_tb_n = 1'b1;
    chk("next head", dout, 18'h1);
    n = 0;
    while (ful === 1'b1 && n < 2) begin
      @(negedge mclk);
      n++;
    end
    chk("room after pop", ful, 1'b0);
    // Non-blocking, so the reader sees the change at its next falling edge only
    rd_en <= 1'b1;
    rd_stall <= 1'b1;
    k = 1;
    n = 0;
    while (k < 257 && n < 800) begin
      @(negedge mclk);
      n++;
      if (got === 1'b1) begin
        chk("drain order", word, 18'(k));
        if (k == 60) rd_stall <= 1'b0;
        if (k == 64) first = n;
        k++;
      end
    end
    chk("drain count", 18'(k), 18'h101);
    chk("no gap", 18'(n - first), 18'h0c0);
    repeat (2) @(negedge mclk);
    chk("drained", emp, 1'b1);
    rd_en = 1'b0;

    // Daisy chain first device: token hand-off on last location
    reset_dut(3'h3);
    n = 0;
    bad = 0;
    for (k = 0; k < 258; k++) begin
      din = 18'(k);
      wen_n = 1'b0;
      @(negedge mclk);
      n += int'(wout_n === 1'b0);
      bad += int'(half_n !== 1'b1);
    end
    wen_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("write token pulses", 18'(n), 18'h1);
    chk("half full unused", 18'(bad), 18'h0);
    chk("daisy full", ful, 1'b0);
    chk("daisy almost full", af_n, 1'b0);
    n = 0;
    ren_tb_n = 1'b0;
    for (k = 0; k < 262; k++) begin
      @(negedge mclk);
      n += int'(rout_n === 1'b0);
    end
    ren_tb_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk("read token pulses", 18'(n), 18'h1);
    chk("daisy empty", emp, 1'b0);
    chk("daisy almost empty", ae_n, 1'b0);
    // Ring neighbour hands the write token back with a one-cycle pulse
    win_n = 1'b0;
    @(negedge mclk);
    win_n = 1'b1;
    din = 18'h3c3c3;
    wen_n = 1'b0;
    @(negedge mclk);
    wen_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("token restored", emp, 1'b1);
    // Read side stays dead until the ring hands the read token back
    ren_tb_n = 1'b0;
    @(negedge mclk);
    ren_tb_n = 1'b1;
    chk("read refused", dout, 18'h000ff);
    rin_n = 1'b0;
    @(negedge mclk);
    rin_n = 1'b1;
    ren_tb_n = 1'b0;
    @(negedge mclk);
    ren_tb_n = 1'b1;
    chk("read token restored", dout, 18'h3c3c3);
    end_sim();
  end
endmodule  // fxc_fifo_core_tb_top
`default_nettype wire
